// ---- pnrd_regs.sv ----
// Paged register file of the network controller core.
// Assumes host pins are synchronous to sys_clk and one access per pulse.
`timescale 1ns/1ps
module pnrd_regs
  import pnrd_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  pnrd_host_req_t       req,
  input  pnrd_core_stat_t      stat,
  input  wire logic [DW-1:0]   flag_set,
  output logic      [DW-1:0]   rd_data,
  output logic                 rd_valid,
  output pnrd_cfg_t            cfg,
  output logic      [DW-1:0]   int_flags,
  output logic      [1:0]      ldma_load,
  output logic      [DW-1:0]   ldma_data
);

  pnrd_main_st_t st;
  pnrd_main_st_t next_st;
  pnrd_page_t    page;
  logic          rd_acc;
  logic          wr_acc;
  logic          acc;
  logic          sig_hit;
  logic          sig_armed;
  logic          flag_clr;
  logic [DW-1:0] rmux;
  logic [2:0]    sta_idx;
  logic [2:0]    grp_idx;

  // Decodes the access kind; both strobes together count as nothing.
  assign rd_acc = req.cs & req.rd & ~req.wr;
  assign wr_acc = req.cs & req.wr & ~req.rd;
  assign acc    = rd_acc | wr_acc;

  // Current page comes from the command register.
  assign page = pnrd_page_t'(st.cfg.command[PS_MSB:PS_LSB]);

  // Byte indices inside the station and group arrays.
  assign sta_idx = 3'(req.offset - OFS_STA_BASE);
  assign grp_idx = 3'(req.offset - OFS_GRP_BASE);

  // Read of the first station byte on the initialization page.
  assign sig_hit = rd_acc && page == PG_INIT && req.offset == OFS_STA_BASE;

  // Flag clears happen on run-time page writes to the flag location.
  assign flag_clr = wr_acc && page == PG_RUN && req.offset == OFS_FLAGS;

  pnrd_sig_track u_sig (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .acc      (acc),
    .hit_read (sig_hit),
    .armed    (sig_armed)
  );

  pnrd_flag_bank u_flags (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .set      (flag_set),
    .clr_we   (flag_clr),
    .clr_data (req.wdata),
    .flags    (int_flags)
  );

  // Read multiplexer; the command byte is visible on every page.
  always_comb begin
    rmux = RSVD_READ;
    if (req.offset == OFS_CMD) begin
      rmux = st.cfg.command;
    end else begin
      unique case (page)
        PG_RUN: begin
          case (req.offset)
            OFS_RSTART: rmux = stat.ldma_lo;
            OFS_RSTOP:  rmux = stat.ldma_hi;
            OFS_BOUND:  rmux = st.cfg.boundary;
            OFS_TSTART: rmux = stat.tx_status;
            OFS_TLEN_L: rmux = stat.collisions;
            OFS_TLEN_H: rmux = stat.fifo;
            OFS_FLAGS:  rmux = int_flags;
            OFS_RSA_L:  rmux = stat.rdma_lo;
            OFS_RSA_H:  rmux = stat.rdma_hi;
            OFS_RCFG:   rmux = stat.rx_status;
            OFS_TCFG:   rmux = stat.tally0;
            OFS_DCFG:   rmux = stat.tally1;
            OFS_MASK:   rmux = stat.tally2;
            default:    rmux = RSVD_READ;
          endcase
        end
        PG_INIT: begin
          if (req.offset == OFS_RECEIVE_CURRENT_PAGE) begin
            rmux = st.cfg.cur_page;
          end else if (req.offset >= OFS_GRP_BASE) begin
            rmux = st.cfg.group[grp_idx];
          end else if (sig_hit && sig_armed) begin
            rmux = SIG_VALUE;
          end else begin
            rmux = st.cfg.station[sta_idx];
          end
        end
        PG_DIAG: begin
          case (req.offset)
            OFS_RSTART: rmux = st.cfg.ring_start;
            OFS_RSTOP:  rmux = st.cfg.ring_stop;
            OFS_RNEXT:  rmux = st.cfg.rnext;
            OFS_TSTART: rmux = st.cfg.tx_start;
            OFS_LNEXT:  rmux = st.cfg.lnext;
            OFS_ACU:    rmux = st.cfg.acnt_hi;
            OFS_ACL:    rmux = st.cfg.acnt_lo;
            OFS_RCFG:   rmux = st.cfg.rx_cfg;
            OFS_TCFG:   rmux = st.cfg.tx_cfg;
            OFS_DCFG:   rmux = st.cfg.data_cfg;
            OFS_MASK:   rmux = st.cfg.int_mask;
            default:    rmux = RSVD_READ;
          endcase
        end
        PG_RSVD: begin
          rmux = RSVD_READ;
        end
      endcase
    end
  end

  // Next state: read capture, write decode and load pulses.
  always_comb begin
    next_st           = st;
    next_st.rvalid    = rd_acc;
    next_st.ldma_load = 2'b00;
    if (rd_acc) begin
      next_st.rdata = rmux;
    end
    if (wr_acc) begin
      if (req.offset == OFS_CMD) begin
        next_st.cfg.command = req.wdata;
      end else begin
        unique case (page)
          PG_RUN: begin
            case (req.offset)
              OFS_RSTART: next_st.cfg.ring_start = req.wdata;
              OFS_RSTOP:  next_st.cfg.ring_stop  = req.wdata;
              OFS_BOUND:  next_st.cfg.boundary   = req.wdata;
              OFS_TSTART: next_st.cfg.tx_start   = req.wdata;
              OFS_TLEN_L: next_st.cfg.tx_len_lo  = req.wdata;
              OFS_TLEN_H: next_st.cfg.tx_len_hi  = req.wdata;
              OFS_RSA_L:  next_st.cfg.rsa_lo     = req.wdata;
              OFS_RSA_H:  next_st.cfg.rsa_hi     = req.wdata;
              OFS_RCNT_L: next_st.cfg.rcnt_lo    = req.wdata;
              OFS_RCNT_H: next_st.cfg.rcnt_hi    = req.wdata;
              OFS_RCFG:   next_st.cfg.rx_cfg     = req.wdata;
              OFS_TCFG:   next_st.cfg.tx_cfg     = req.wdata;
              OFS_DCFG:   next_st.cfg.data_cfg   = req.wdata;
              OFS_MASK:   next_st.cfg.int_mask   = req.wdata;
              default:    next_st.cfg            = st.cfg;
            endcase
          end
          PG_INIT: begin
            if (req.offset == OFS_RECEIVE_CURRENT_PAGE) begin
              next_st.cfg.cur_page = req.wdata;
            end else if (req.offset >= OFS_GRP_BASE) begin
              next_st.cfg.group[grp_idx] = req.wdata;
            end else begin
              next_st.cfg.station[sta_idx] = req.wdata;
            end
          end
          PG_DIAG: begin
            case (req.offset)
              OFS_RSTART: begin
                next_st.ldma_load = 2'b01;
                next_st.ldma_data = req.wdata;
              end
              OFS_RSTOP: begin
                next_st.ldma_load = 2'b10;
                next_st.ldma_data = req.wdata;
              end
              OFS_RNEXT: next_st.cfg.rnext   = req.wdata;
              OFS_LNEXT: next_st.cfg.lnext   = req.wdata;
              OFS_ACU:   next_st.cfg.acnt_hi = req.wdata;
              OFS_ACL:   next_st.cfg.acnt_lo = req.wdata;
              default:   next_st.cfg         = st.cfg;
            endcase
          end
          PG_RSVD: begin
            next_st.cfg = st.cfg;
          end
        endcase
      end
    end
  end

  // Registers the whole decoder state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st             <= '0;
      st.cfg.command <= CMD_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state registers.
  assign rd_data   = st.rdata;
  assign rd_valid  = st.rvalid;
  assign cfg       = st.cfg;
  assign ldma_load = st.ldma_load;
  assign ldma_data = st.ldma_data;

  // Each read is answered one cycle later with a valid strobe.
  property p_read_answer;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_acc |=> rd_valid ##1 !rd_valid || $past(rd_acc);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read not answered in one cycle.");

  // Selecting the initialization page makes the next read see it.
  property p_page_select;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && req.offset == OFS_CMD
        && req.wdata[PS_MSB:PS_LSB] == PG_INIT)
      ##1 !wr_acc ##1 (rd_acc && req.offset == OFS_RECEIVE_CURRENT_PAGE)
      |=> rd_data == $past(st.cfg.cur_page);
  endproperty
  a_page_select: assert property (p_page_select)
    else $error("Page select did not reach the decoder.");

  // The command byte reads back at offset zero on any page.
  property p_cmd_any_page;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_acc && req.offset == OFS_CMD) |=> rd_data == $past(cfg.command);
  endproperty
  a_cmd_any_page: assert property (p_cmd_any_page)
    else $error("Command byte not read at offset zero.");

  // Run-time reads of the transmit start offset show transmit status.
  property p_run_asym;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_acc && page == PG_RUN && req.offset == OFS_TSTART)
      |=> rd_data == $past(stat.tx_status);
  endproperty
  a_run_asym: assert property (p_run_asym)
    else $error("Run-time read did not return transmit status.");

  // Diagnostic reads of the receive setup offset show receive setup.
  property p_diag_readback;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_acc && page == PG_DIAG && req.offset == OFS_RCFG)
      |=> rd_data == $past(cfg.rx_cfg);
  endproperty
  a_diag_readback: assert property (p_diag_readback)
    else $error("Diagnostic read-back wrong.");

  // Diagnostic writes in the upper range leave all setup unchanged.
  property p_diag_ignore;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && page == PG_DIAG && req.offset >= OFS_RCFG)
      |=> cfg == $past(cfg);
  endproperty
  a_diag_ignore: assert property (p_diag_ignore)
    else $error("Ignored diagnostic write changed setup.");

  // Reserved page reads away from offset zero give the fixed value.
  property p_rsvd_page;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_acc && page == PG_RSVD && req.offset != OFS_CMD)
      |=> rd_data == RSVD_READ;
  endproperty
  a_rsvd_page: assert property (p_rsvd_page)
    else $error("Reserved page read not fixed.");

  // Two reads of station byte zero, no access between, give the signature.
  property p_signature;
    @(posedge sys_clk) disable iff (!rst_n)
      (((sig_hit && !sig_armed) ##1 sig_hit)
        or ((sig_hit && !sig_armed) ##1 !acc ##1 sig_hit))
      |=> rd_data == SIG_VALUE;
  endproperty
  a_signature: assert property (p_signature)
    else $error("Signature not returned on second read.");

  // The reserved run-time location at offset 10 reads as the fixed value.
  property p_rsvd_loc;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_acc && page == PG_RUN && req.offset == OFS_RCNT_L)
      |=> rd_data == RSVD_READ;
  endproperty
  a_rsvd_loc: assert property (p_rsvd_loc)
    else $error("Reserved location read not fixed.");

  // A written current page byte appears in the setup at the next edge.
  property p_init_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && page == PG_INIT && req.offset == OFS_RECEIVE_CURRENT_PAGE)
      |=> cfg.cur_page == $past(req.wdata);
  endproperty
  a_init_write: assert property (p_init_write)
    else $error("Current page byte not stored.");

  // Read data holds while no read is taken.
  property p_rd_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !rd_acc |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data changed without a read.");

  // Diagnostic writes at offset one pulse the local address low load.
  property p_ldma_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && page == PG_DIAG && req.offset == OFS_RSTART)
      |=> ldma_load == 2'b01 && ldma_data == $past(req.wdata);
  endproperty
  a_ldma_pulse: assert property (p_ldma_pulse)
    else $error("Local address load pulse missing.");

  // Reserved diagnostic writes leave every setup byte unchanged.
  property p_rsvd_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && page == PG_DIAG
        && req.offset >= OFS_RSA_L && req.offset <= OFS_RCNT_H)
      |=> cfg == $past(cfg);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("Reserved write changed setup.");

  // Flag writes clear every bit written one that no event sets.
  property p_flag_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      flag_clr |=> (int_flags & $past(req.wdata & ~flag_set)) == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Written flag bits not cleared.");

endmodule

// ---- pnrd_pkg.sv ----
// Shared constants and carrier types for the paged register decoder.
// Assumes one 20 MHz clock and host pins sampled synchronously to it.
package pnrd_pkg;

  // Clock rate of the block, kept for reference by users of the package.
  localparam int unsigned CLK_HZ = 20_000_000;

  // Every register of the core is one byte wide.
  localparam int DW = 8;

  // Register offsets shared by several pages.
  localparam logic [3:0] OFS_CMD      = 4'h0;
  localparam logic [3:0] OFS_RSTART   = 4'h1;
  localparam logic [3:0] OFS_RSTOP    = 4'h2;
  localparam logic [3:0] OFS_BOUND    = 4'h3;
  localparam logic [3:0] OFS_TSTART   = 4'h4;
  localparam logic [3:0] OFS_TLEN_L   = 4'h5;
  localparam logic [3:0] OFS_TLEN_H   = 4'h6;
  localparam logic [3:0] OFS_FLAGS    = 4'h7;
  localparam logic [3:0] OFS_RSA_L    = 4'h8;
  localparam logic [3:0] OFS_RSA_H    = 4'h9;
  localparam logic [3:0] OFS_RCNT_L   = 4'hA;
  localparam logic [3:0] OFS_RCNT_H   = 4'hB;
  localparam logic [3:0] OFS_RCFG     = 4'hC;
  localparam logic [3:0] OFS_TCFG     = 4'hD;
  localparam logic [3:0] OFS_DCFG     = 4'hE;
  localparam logic [3:0] OFS_MASK     = 4'hF;
  // Offsets of the initialization page.
  localparam logic [3:0] OFS_STA_BASE = 4'h1;
  localparam logic [3:0] OFS_RECEIVE_CURRENT_PAGE     = 4'h7;
  localparam logic [3:0] OFS_GRP_BASE = 4'h8;
  // Offsets of the diagnostic page that differ from the run-time names.
  localparam logic [3:0] OFS_RNEXT    = 4'h3;
  localparam logic [3:0] OFS_LNEXT    = 4'h5;
  localparam logic [3:0] OFS_ACU      = 4'h6;
  localparam logic [3:0] OFS_ACL      = 4'h7;

  // Page select field inside the command register.
  localparam int PS_LSB = 6;
  localparam int PS_MSB = 7;

  // Reset and fixed read values.
  localparam logic [7:0] CMD_RST    = 8'h01;
  localparam logic [7:0] RSVD_READ  = 8'hFF;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Signature byte; the value is arbitrary.
  localparam logic [7:0] SIG_VALUE  = 8'h5A;

  // Page select codes.
  typedef enum logic [1:0] {
    PG_RUN  = 2'b00,
    PG_INIT = 2'b01,
    PG_DIAG = 2'b10,
    PG_RSVD = 2'b11
  } pnrd_page_t;

  // One host access as seen on the pins.
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [3:0] offset;
    logic [7:0] wdata;
  } pnrd_host_req_t;

  // Live values that the core shows through read-only locations.
  typedef struct packed {
    logic [7:0] ldma_lo;
    logic [7:0] ldma_hi;
    logic [7:0] tx_status;
    logic [7:0] collisions;
    logic [7:0] fifo;
    logic [7:0] rdma_lo;
    logic [7:0] rdma_hi;
    logic [7:0] rx_status;
    logic [7:0] tally0;
    logic [7:0] tally1;
    logic [7:0] tally2;
  } pnrd_core_stat_t;

  // Every byte that software writes and the core uses.
  typedef struct packed {
    logic [7:0]      command;
    logic [7:0]      ring_start;
    logic [7:0]      ring_stop;
    logic [7:0]      boundary;
    logic [7:0]      tx_start;
    logic [7:0]      tx_len_lo;
    logic [7:0]      tx_len_hi;
    logic [7:0]      rsa_lo;
    logic [7:0]      rsa_hi;
    logic [7:0]      rcnt_lo;
    logic [7:0]      rcnt_hi;
    logic [7:0]      rx_cfg;
    logic [7:0]      tx_cfg;
    logic [7:0]      data_cfg;
    logic [7:0]      int_mask;
    logic [5:0][7:0] station;
    logic [7:0]      cur_page;
    logic [7:0][7:0] group;
    logic [7:0]      rnext;
    logic [7:0]      lnext;
    logic [7:0]      acnt_hi;
    logic [7:0]      acnt_lo;
  } pnrd_cfg_t;

  // Whole state of the decoder.
  typedef struct packed {
    pnrd_cfg_t  cfg;
    logic [7:0] rdata;
    logic       rvalid;
    logic [1:0] ldma_load;
    logic [7:0] ldma_data;
  } pnrd_main_st_t;

endpackage

// ---- pnrd_flag_bank.sv ----
// Sticky event flags, cleared by writing one to a bit.
// Assumes set pulses and clear strobe are synchronous to sys_clk.
`timescale 1ns/1ps
module pnrd_flag_bank
  import pnrd_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic [DW-1:0] set,
  input  wire logic          clr_we,
  input  wire logic [DW-1:0] clr_data,
  output logic      [DW-1:0] flags
);

  logic [DW-1:0] st;
  logic [DW-1:0] next_st;

  // Each bit sets on its event and clears on a one; set wins.
  genvar i;
  generate
    for (i = 0; i < DW; i++) begin : g_bit
      always_comb begin
        next_st[i] = set[i] | (st[i] & ~(clr_we & clr_data[i]));
      end
    end
  endgenerate

  // Registers the flag bank.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st;

  // A set in the same cycle as its clear leaves the bit high.
  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
      (clr_we && (set & clr_data) != '0)
      |=> (flags & $past(set)) == $past(set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Flag lost when set met clear.");

endmodule

// ---- pnrd_sig_track.sv ----
// Tracks back-to-back reads of the first station byte location.
// Assumes acc is high for exactly one cycle per host access.
`timescale 1ns/1ps
module pnrd_sig_track
  import pnrd_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic acc,
  input  wire logic hit_read,
  output logic      armed
);

  logic st;
  logic next_st;

  // A first hit arms, the next access of any kind disarms.
  always_comb begin
    next_st = st;
    if (acc) begin
      next_st = hit_read & ~st;
    end
  end

  // Registers the armed flag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign armed = st;

  // Any access that is not a hit leaves the tracker disarmed.
  property p_other_disarms;
    @(posedge sys_clk) disable iff (!rst_n)
      (acc && !hit_read) |=> !armed;
  endproperty
  a_other_disarms: assert property (p_other_disarms)
    else $error("Tracker stayed armed after another access.");

endmodule

// ---- pnrd_host_model.sv ----
// Host processor model that makes single byte accesses on the host pins.
// Assumes the decoder answers a read with a one-cycle valid the next edge.
`timescale 1ns/1ps
module pnrd_host_model
  import pnrd_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic [DW-1:0] rd_data,
  input  wire logic          rd_valid,
  output pnrd_host_req_t     req
);
  // The pins start idle so no access is seen during reset.
  initial req = '0;

  // One access: drive after an edge, held through the taking edge.
  task automatic access(input logic w, input logic [3:0] ofs,
                        input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    req.cs = 1'b1;
    req.rd = !w;
    req.wr = w;
    req.offset = ofs;
    req.wdata = d;
    @(posedge sys_clk);
    #2;
    req.cs = 1'b0;
    req.rd = 1'b0;
    req.wr = 1'b0;
    // Released lines carry the inverse so stale data never looks valid.
    req.offset = ~ofs;
    req.wdata = ~d;
  endtask

  // Diagnostic page writes are issued only by diagnostic tests.
  // Writes while page three is selected are never issued.
  task automatic write_byte(input logic [3:0] ofs, input logic [7:0] d);
    access(1'b1, ofs, d);
  endtask

  // The answer is taken in the single cycle in which it is valid.
  task automatic read_byte(input logic [3:0] ofs, output logic [7:0] d);
    access(1'b0, ofs, 8'h00);
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule

// ---- pnrd_regs_bench.sv ----
// Self-checking bench for the paged register decoder.
// Assumes the host model drives every access and the clock is 20 MHz.
`timescale 1ns/1ps
module pnrd_regs_bench;
  import pnrd_pkg::*;

  logic            sys_clk;
  logic            rst_n;
  pnrd_host_req_t  req;
  pnrd_core_stat_t stat;
  logic [DW-1:0]   flag_set;
  logic [DW-1:0]   rd_data;
  logic            rd_valid;
  pnrd_cfg_t       cfg;
  logic [DW-1:0]   int_flags;
  logic [1:0]      ldma_load;
  logic [DW-1:0]   ldma_data;
  logic [7:0]      e;
  int              failures;
  int              comparisons;

  // Each live status byte equals A0H plus the offset that shows it.
  assign stat = {8'hA1, 8'hA2, 8'hA4, 8'hA5, 8'hA6, 8'hA8, 8'hA9,
                 8'hAC, 8'hAD, 8'hAE, 8'hAF};

  pnrd_regs i_pnrd_regs (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .req       (req),
    .stat      (stat),
    .flag_set  (flag_set),
    .rd_data   (rd_data),
    .rd_valid  (rd_valid),
    .cfg       (cfg),
    .int_flags (int_flags),
    .ldma_load (ldma_load),
    .ldma_data (ldma_data)
  );

  pnrd_host_model i_pnrd_host_model (
    .sys_clk  (sys_clk),
    .rd_data  (rd_data),
    .rd_valid (rd_valid),
    .req      (req)
  );

  // The clock toggles every 25 ns, a period of 50 ns.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Prints the verdict once and ends the run.
  task automatic print_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads one location and compares it with the expected byte.
  task automatic rdc(input logic [3:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    i_pnrd_host_model.read_byte(ofs, d);
    chk(d, exp);
  endtask

  // Writes one location through the host model.
  task automatic wrb(input logic [3:0] ofs, input logic [7:0] d);
    i_pnrd_host_model.write_byte(ofs, d);
  endtask

  // Selects a page with the stop bit kept high.
  task automatic pg(input logic [1:0] p);
    wrb(4'h0, {p, 6'h01});
  endtask

  // Main sequence of tests.
  initial begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    flag_set = '0;
    repeat (20) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    rdc(4'h0, 8'h01);
    // Run-time page: writes load setup, reads show live status except boundary at 3, flags at 7 and fixed value at 10, 11.
    for (int o = 1; o < 16; o++) wrb(4'(o), 8'h50 + 8'(o));
    for (int o = 1; o < 16; o++) begin
      case (o)
        3: e = 8'h53;
        7: e = 8'h00;
        10, 11: e = RSVD_READ;
        default: e = 8'hA0 | 8'(o);
      endcase
      rdc(4'(o), e);
    end
    chk(cfg.tx_cfg, 8'h5D);
    chk(cfg.rcnt_lo, 8'h5A);
    // Flags are set by the core and cleared by writing ones.
    @(posedge sys_clk);
    #2;
    flag_set = 8'h24;
    @(posedge sys_clk);
    #2;
    flag_set = 8'h00;
    rdc(4'h7, 8'h24);
    wrb(4'h7, 8'h04);
    rdc(4'h7, 8'h20);
    // An event in the same cycle as its clear keeps the flag.
    fork
      wrb(4'h7, 8'h20);
      begin
        @(posedge sys_clk);
        #2;
        flag_set = 8'h28;
        @(posedge sys_clk);
        #2;
        flag_set = 8'h00;
      end
    join
    rdc(4'h7, 8'h28);
    chk(int_flags, 8'h28);
    // Initialization page: every location reads back what was written.
    pg(2'b01);
    rdc(4'h7, 8'h00);
    for (int o = 1; o < 16; o++) wrb(4'(o), 8'h10 + 8'(o));
    for (int o = 1; o < 16; o++) rdc(4'(o), 8'h10 + 8'(o));
    // Back-to-back reads of offset one expose the signature once.
    rdc(4'h1, 8'h11);
    rdc(4'h1, SIG_VALUE);
    rdc(4'h1, 8'h11);
    wrb(4'h2, 8'h12);
    rdc(4'h1, 8'h11);
    // Diagnostic page reads back write-only setup; some writes are lost.
    pg(2'b10);
    for (int pass = 0; pass < 2; pass++) begin
      for (int o = 1; o < 16; o++) begin
        if (o inside {1, 2, 4, [12:15]}) begin
          rdc(4'(o), 8'h50 + 8'(o));
          if (pass == 0 && (o == 4 || o >= 12)) wrb(4'(o), 8'hFF);
        end
      end
    end
    chk(cfg.int_mask, 8'h5F);
    for (int o = 8; o < 12; o++) begin
      wrb(4'(o), 8'h00);
      rdc(4'(o), RSVD_READ);
    end
    chk(cfg.rsa_lo, 8'h58);
    wrb(4'h1, 8'h77);
    chk({6'h00, ldma_load}, 8'h01);
    chk(ldma_data, 8'h77);
    wrb(4'h3, 8'h33);
    rdc(4'h3, 8'h33);
    // Reserved page: only the command location answers.
    pg(2'b11);
    rdc(4'h5, RSVD_READ);
    rdc(4'h0, 8'hC1);
    // A second reset takes the decoder back out of the reserved page.
    @(posedge sys_clk);
    #2;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    rdc(4'h0, 8'h01);
    rdc(4'h1, 8'hA1);
    print_verdict();
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #200_000;
    failures++;
    print_verdict();
  end
endmodule
